// ===== include/cc_pkg.sv
package cc_pkg;

  // Debounce and toggle times, in microseconds, and the clock rate in kHz
  localparam int CLK_KHZ = 10000;
  localparam int CC_DEBOUNCE_US = 150;
  localparam int TOGGLE_HALF_US = 50;
  localparam int CC_DEBOUNCE_CYCLES = (CC_DEBOUNCE_US * CLK_KHZ + 999) / 1000;
  localparam int TOGGLE_HALF_CYCLES = (TOGGLE_HALF_US * CLK_KHZ) / 1000;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] TOGGLE_OFS = 8'h08;

  // Control fields
  localparam int CTRL_ROLE_LSB = 0;
  localparam int CTRL_TRY_SOURCE_BIT = 2;
  localparam int CTRL_TRY_SINK_BIT = 3;
  localparam int CTRL_RP_LSB = 4;
  localparam int CTRL_DIRECT_BIT = 6;
  localparam int CTRL_ENABLE_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h80;

  // Status fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_VBUS_EN_BIT = 4;
  localparam int STAT_VCONN_EN_BIT = 5;
  localparam int STAT_CURRENT_LSB = 6;
  localparam int STAT_PD_BIT = 8;
  localparam int STAT_PU_BIT = 9;
  localparam int STAT_VBUS_BIT = 10;

  typedef enum logic [1:0] {
    role_source,
    role_sink,
    role_dual
  } port_role_t;

  typedef enum logic [3:0] {
    unattached_source,
    attach_wait_source,
    attached_source,
    unattached_sink,
    attach_wait_sink,
    attached_sink,
    try_source,
    try_sink
  } cc_state_t;

endpackage

// ===== core/cc_connection_state_machine.sv
`timescale 1ns/100ps

module cc_connection_state_machine #(
  parameter int DEBOUNCE_CYCLES = cc_pkg::CC_DEBOUNCE_CYCLES,
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cc1_pd_raw,
  input wire logic cc2_pd_raw,
  input wire logic cc_pu_raw,
  input wire logic vbus_raw,
  input wire logic [1:0] rd_voltage_raw,
  output logic vbus_en,
  output logic vconn_en,
  output logic rp_en,
  output logic rd_en,
  output logic [1:0] rp_level,
  output logic [1:0] sink_current,
  output logic attached
);

  localparam int SYNC_W = 6;
  localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DEBOUNCE_CYCLES - 1);

  // Two-stage synchronisers for the analog comparator outputs
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;
  assign raw_in = {rd_voltage_raw, vbus_raw, cc_pu_raw, cc2_pd_raw, cc1_pd_raw};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= raw_in[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  logic pd_any;
  logic pu_seen;
  logic vbus_seen;
  logic [1:0] rd_level;
  assign pd_any = sync_ff[0] | sync_ff[1];
  assign pu_seen = sync_ff[2];
  assign vbus_seen = sync_ff[3];
  assign rd_level = sync_ff[5:4];

  // Registers
  logic [7:0] ctrl_ff;
  logic [CNT_W-1:0] toggle_half_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  cc_pkg::cc_state_t state_ff;
  cc_pkg::cc_state_t nxt_state;

  logic [1:0] role;
  logic is_dual;
  logic use_try_source;
  logic use_try_sink;
  logic direct_sink;
  logic enable;
  assign role = ctrl_ff[cc_pkg::CTRL_ROLE_LSB +: 2];
  assign is_dual = (role == cc_pkg::role_dual);
  // Both set means neither, so the port never runs the two at once
  assign use_try_source = is_dual & ctrl_ff[cc_pkg::CTRL_TRY_SOURCE_BIT] & ~ctrl_ff[cc_pkg::CTRL_TRY_SINK_BIT];
  assign use_try_sink = is_dual & ctrl_ff[cc_pkg::CTRL_TRY_SINK_BIT] & ~ctrl_ff[cc_pkg::CTRL_TRY_SOURCE_BIT];
  assign direct_sink = (role == cc_pkg::role_sink) & ctrl_ff[cc_pkg::CTRL_DIRECT_BIT];
  assign enable = ctrl_ff[cc_pkg::CTRL_ENABLE_BIT];

  function automatic logic is_src_state(input cc_pkg::cc_state_t s);
    return (s == cc_pkg::unattached_source) || (s == cc_pkg::attach_wait_source) ||
           (s == cc_pkg::attached_source) || (s == cc_pkg::try_source);
  endfunction

  // Wishbone slave: ack one cycle after the request is seen, dropped the next cycle
  logic wb_req;
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_req;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= cc_pkg::CTRL_RESET;
      toggle_half_ff <= CNT_W'(cc_pkg::TOGGLE_HALF_CYCLES);
    end else if (wb_req && wb_we_i) begin
      if (wb_adr_i == cc_pkg::CTRL_OFS && wb_sel_i[0]) begin
        ctrl_ff <= wb_dat_i[7:0];
      end
      if (wb_adr_i == cc_pkg::TOGGLE_OFS) begin
        if (wb_sel_i[0]) begin
          toggle_half_ff[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          toggle_half_ff[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[cc_pkg::STAT_STATE_LSB +: 4] = state_ff;
    status_word[cc_pkg::STAT_VBUS_EN_BIT] = vbus_en;
    status_word[cc_pkg::STAT_VCONN_EN_BIT] = vconn_en;
    status_word[cc_pkg::STAT_CURRENT_LSB +: 2] = sink_current;
    status_word[cc_pkg::STAT_PD_BIT] = pd_any;
    status_word[cc_pkg::STAT_PU_BIT] = pu_seen;
    status_word[cc_pkg::STAT_VBUS_BIT] = vbus_seen;
  end

  // Unmapped addresses are acknowledged and read as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        cc_pkg::CTRL_OFS: rdata_ff <= {24'h00_0000, ctrl_ff};
        cc_pkg::STATUS_OFS: rdata_ff <= status_word;
        cc_pkg::TOGGLE_OFS: rdata_ff <= {16'h0000, toggle_half_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // Toggle divider: a one-cycle tick each half period of the dual-role toggle
  logic [CNT_W-1:0] tog_cnt_ff;
  logic tog_tick;
  assign tog_tick = (tog_cnt_ff >= toggle_half_ff);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_cnt_ff <= '0;
    end else if (tog_tick || nxt_state != state_ff) begin
      tog_cnt_ff <= '0;
    end else begin
      tog_cnt_ff <= tog_cnt_ff + 1'b1;
    end
  end

  // Debounce counter, restarted on any change of the pull-up or pull-down sense or of state; VBUS changes do not restart it
  logic [1:0] sense_prev_ff;
  logic [CNT_W-1:0] aws_run_ff;
  logic [CNT_W-1:0] deb_cnt_ff;
  logic deb_done;
  assign deb_done = (deb_cnt_ff >= DEB_LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_prev_ff <= 2'h0;
      aws_run_ff <= '0;
    end else begin
      sense_prev_ff <= {pu_seen, pd_any};
      aws_run_ff <= (state_ff == cc_pkg::attach_wait_source && pd_any) ? aws_run_ff + 1'b1 : '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      deb_cnt_ff <= '0;
    end else if (nxt_state != state_ff || {pu_seen, pd_any} != sense_prev_ff) begin
      deb_cnt_ff <= '0;
    end else if (!deb_done) begin
      deb_cnt_ff <= deb_cnt_ff + 1'b1;
    end
  end

  cc_pkg::cc_state_t idle_state;
  assign idle_state = (role == cc_pkg::role_source) ? cc_pkg::unattached_source : cc_pkg::unattached_sink;

  always_comb begin
    nxt_state = state_ff;
    if (!enable) begin
      nxt_state = idle_state;
    end else begin
      unique case (state_ff)
        cc_pkg::unattached_source: begin
          if (role == cc_pkg::role_sink) begin
            nxt_state = cc_pkg::unattached_sink;
          end else if (pd_any) begin
            nxt_state = cc_pkg::attach_wait_source;
          end else if (is_dual && tog_tick) begin
            nxt_state = cc_pkg::unattached_sink;
          end
        end
        cc_pkg::attach_wait_source: begin
          if (!pd_any) begin
            nxt_state = is_dual ? cc_pkg::unattached_sink : cc_pkg::unattached_source;
          end else if (deb_done) begin
            nxt_state = use_try_sink ? cc_pkg::try_sink : cc_pkg::attached_source;
          end
        end
        cc_pkg::attached_source: begin
          if (!pd_any) begin
            nxt_state = is_dual ? cc_pkg::unattached_sink : cc_pkg::unattached_source;
          end
        end
        cc_pkg::unattached_sink: begin
          if (role == cc_pkg::role_source) begin
            nxt_state = cc_pkg::unattached_source;
          end else if (direct_sink && vbus_seen) begin
            nxt_state = cc_pkg::attached_sink;
          end else if (pu_seen) begin
            nxt_state = cc_pkg::attach_wait_sink;
          end else if (is_dual && tog_tick) begin
            nxt_state = cc_pkg::unattached_source;
          end
        end
        cc_pkg::attach_wait_sink: begin
          if (!pu_seen) begin
            nxt_state = is_dual ? cc_pkg::unattached_source : cc_pkg::unattached_sink;
          end else if (deb_done && vbus_seen) begin
            nxt_state = use_try_source ? cc_pkg::try_source : cc_pkg::attached_sink;
          end
        end
        cc_pkg::attached_sink: begin
          if (!vbus_seen) begin
            nxt_state = cc_pkg::unattached_sink;
          end
        end
        cc_pkg::try_source: begin
          // Gives up after one toggle half period so a source partner cannot hang it
          if (pd_any) begin
            nxt_state = cc_pkg::attached_source;
          end else if (tog_tick) begin
            nxt_state = cc_pkg::unattached_sink;
          end
        end
        cc_pkg::try_sink: begin
          if (pu_seen && vbus_seen) begin
            nxt_state = cc_pkg::attached_sink;
          end else if (tog_tick) begin
            nxt_state = cc_pkg::unattached_source;
          end
        end
        default: nxt_state = idle_state;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= cc_pkg::unattached_source;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Pin controls follow the next state so they change with the state itself
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vbus_en <= 1'b0;
      vconn_en <= 1'b0;
      rp_en <= 1'b0;
      rd_en <= 1'b0;
      attached <= 1'b0;
    end else begin
      vbus_en <= (nxt_state == cc_pkg::attached_source);
      vconn_en <= (nxt_state == cc_pkg::attached_source);
      rp_en <= is_src_state(nxt_state);
      rd_en <= ~is_src_state(nxt_state);
      attached <= (nxt_state == cc_pkg::attached_source) || (nxt_state == cc_pkg::attached_sink);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rp_level <= 2'h0;
      sink_current <= 2'h0;
    end else begin
      rp_level <= ctrl_ff[cc_pkg::CTRL_RP_LSB +: 2];
      sink_current <= (nxt_state == cc_pkg::attached_sink) ? rd_level : 2'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pulldown_enters_wait: assert property (
    state_ff == cc_pkg::unattached_source && enable && role != cc_pkg::role_sink && pd_any
    |=> state_ff == cc_pkg::attach_wait_source)
    else $error("pull-down did not start source attach wait");
  a_debounce_before_attach: assert property (
    state_ff == cc_pkg::attach_wait_source ##1 state_ff inside {cc_pkg::attached_source, cc_pkg::try_sink}
    |-> $past(aws_run_ff) >= DEB_LAST)
    else $error("source attach wait left before debounce elapsed");
  a_supplies_on_attach: assert property (
    state_ff == cc_pkg::attached_source |-> vbus_en && vconn_en && rp_en && !rd_en)
    else $error("supplies not on while attached as source");
  a_pullup_enters_wait: assert property (
    state_ff == cc_pkg::unattached_sink && enable && role == cc_pkg::role_dual && pu_seen
    |=> state_ff == cc_pkg::attach_wait_sink)
    else $error("pull-up did not start sink attach wait");
  a_sink_needs_vbus: assert property (
    state_ff == cc_pkg::attach_wait_sink ##1 state_ff == cc_pkg::attached_sink
    |-> $past(vbus_seen) && $past(deb_done))
    else $error("sink attached without vbus or debounce");
  a_sink_vbus_detach: assert property (
    state_ff == cc_pkg::attached_sink && enable && !vbus_seen
    |=> state_ff == cc_pkg::unattached_sink ##1 !vbus_en)
    else $error("sink did not detach on vbus loss");
  a_dual_src_detach: assert property (
    state_ff == cc_pkg::attached_source && enable && is_dual && !pd_any
    |=> state_ff == cc_pkg::unattached_sink && !vbus_en && !vconn_en && rd_en)
    else $error("dual-role source detach not handled");
  a_src_only_detach: assert property (
    state_ff == cc_pkg::attached_source && enable && role == cc_pkg::role_source && !pd_any
    |=> state_ff == cc_pkg::unattached_source)
    else $error("source-only detach not handled");
  a_try_never_both: assert property (
    nxt_state != state_ff && (nxt_state == cc_pkg::try_source || nxt_state == cc_pkg::try_sink)
    |-> ctrl_ff[cc_pkg::CTRL_TRY_SOURCE_BIT] != ctrl_ff[cc_pkg::CTRL_TRY_SINK_BIT])
    else $error("role reversal entered with both or neither mode set");
  a_toggle_alternates: assert property (
    state_ff == cc_pkg::unattached_source && enable && is_dual && !pd_any && tog_tick
    |=> state_ff == cc_pkg::unattached_sink)
    else $error("dual-role port did not toggle");
  c_source_attach: cover property (state_ff == cc_pkg::attach_wait_source ##1 state_ff == cc_pkg::attached_source);
  c_sink_attach: cover property (state_ff == cc_pkg::attach_wait_sink ##1 state_ff == cc_pkg::attached_sink);
  c_try_source_win: cover property (state_ff == cc_pkg::try_source ##1 state_ff == cc_pkg::attached_source);
  c_try_sink_win: cover property (state_ff == cc_pkg::try_sink ##1 state_ff == cc_pkg::attached_sink);

endmodule

// ===== verification/cc_far_port.sv
`timescale 1ns/100ps

// Far-side port: mode 0 absent, 1 sink, 2 source, 3 supply without pull-up
module cc_far_port #(
  parameter int VBUS_DLY = 30
) (
  input wire logic clk,
  input wire logic [1:0] mode,
  input wire logic pin_sel,
  input wire logic [1:0] advert,
  input wire logic rp_en,
  input wire logic rd_en,
  output logic cc1_pd,
  output logic cc2_pd,
  output logic cc_pu,
  output logic vbus,
  output logic [1:0] rd_v
);
  int cnt_ff;

  // A source powers VBUS only after seeing our pull-down for a while, so sinks see CC before VBUS
  always_ff @(posedge clk) begin
    if (mode[1] && (rd_en || mode[0]))
      cnt_ff <= cnt_ff + 1;
    else
      cnt_ff <= 0;
  end

  assign vbus = mode[1] && cnt_ff >= VBUS_DLY;
  assign cc_pu = mode == 2'h2;
  // A pull-down is only visible while the other end pulls up
  assign cc1_pd = mode == 2'h1 && rp_en && !pin_sel;
  assign cc2_pd = mode == 2'h1 && rp_en && pin_sel;
  assign rd_v = (mode == 2'h2 && rd_en) ? advert : 2'h0;
endmodule

// ===== verification/tb_cc_connection_state_machine.sv
`timescale 1ns/100ps

module tb_cc_connection_state_machine;
  logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  logic cc1_pd_raw, cc2_pd_raw, cc_pu_raw, vbus_raw;
  logic [1:0] rd_voltage_raw, rp_level, sink_current, mode, adv, rpv;
  logic vbus_en, vconn_en, rp_en, rd_en, attached, psel;
  int fail_count = 0;
  int cmp_count = 0;
  typedef struct {logic [31:0] e; logic [31:0] m;} note_t;
  note_t q[$];
  note_t n;

  cc_connection_state_machine #(.DEBOUNCE_CYCLES(8)) u_dut (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cc1_pd_raw, .cc2_pd_raw, .cc_pu_raw, .vbus_raw,
    .rd_voltage_raw, .vbus_en, .vconn_en, .rp_en, .rd_en, .rp_level, .sink_current, .attached);
  cc_far_port u_far (.clk, .mode, .pin_sel(psel), .advert(adv), .rp_en, .rd_en, .cc1_pd(cc1_pd_raw),
    .cc2_pd(cc2_pd_raw), .cc_pu(cc_pu_raw), .vbus(vbus_raw), .rd_v(rd_voltage_raw));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Entered just after a rising edge; holds the request until ack is sampled
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{e, m});
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wait_st(input cc_pkg::cc_state_t s);
    int k;
    k = 0;
    do begin
      rd(cc_pkg::STATUS_OFS, 32'h0, 32'h0);
      k++;
    end while (r[3:0] !== s && k < 300);
    chk({28'h0, r[3:0]}, {28'h0, s});
  endtask

  function automatic logic [31:0] st(input cc_pkg::cc_state_t s, input logic [1:0] sup);
    return {26'h0, sup, s};
  endfunction

  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q.size() > 0) begin
      n = q.pop_front();
      chk(wb_dat_o & n.m, n.e & n.m);
    end
  end

  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    mode = 2'h0;
    psel = 1'b0;
    adv = 2'h0;
    void'($urandom(36));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk(32'({rp_en, rd_en, vbus_en, vconn_en, attached}), 32'h10);
    @(posedge clk);
    rd(cc_pkg::CTRL_OFS, 32'(cc_pkg::CTRL_RESET), 32'hFFFFFFFF);
    rd(cc_pkg::TOGGLE_OFS, 32'(cc_pkg::TOGGLE_HALF_CYCLES), 32'hFFFFFFFF);
    // Shorter toggle half period than the reset value, still long enough that the try windows outlast the polling
    wr(cc_pkg::TOGGLE_OFS, 32'hABCD0064);
    rd(cc_pkg::TOGGLE_OFS, 32'h64, 32'hFFFFFFFF);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    wb_sel_i <= 4'hE;
    wr(cc_pkg::CTRL_OFS, 32'h41);
    wb_sel_i <= 4'hF;
    rd(cc_pkg::CTRL_OFS, 32'h80, 32'hFFFFFFFF);
    // Source role against a sink on a random CC pin
    psel <= 1'($urandom);
    mode <= 2'h1;
    repeat (10) @(posedge clk);
    #1 chk(32'(vbus_en), 32'h0);
    @(posedge clk);
    #1 chk(32'({vbus_en, vconn_en, attached}), 32'h7);
    @(posedge clk);
    rpv = 2'($urandom);
    wr(cc_pkg::CTRL_OFS, 32'h80 | 32'(rpv) << 4);
    @(posedge clk);
    #1 chk(32'(rp_level), 32'(rpv));
    @(posedge clk);
    rd(cc_pkg::STATUS_OFS, st(cc_pkg::attached_source, 2'b11), 32'h3F);
    mode <= 2'h0;
    wait_st(cc_pkg::unattached_source);
    #1 chk(32'({vbus_en, vconn_en}), 32'h0);
    @(posedge clk);
    // Sink role against a source
    wr(cc_pkg::CTRL_OFS, 32'h81);
    mode <= 2'h2;
    adv <= 2'($urandom);
    wait_st(cc_pkg::attach_wait_sink);
    repeat (10) @(posedge clk);
    rd(cc_pkg::STATUS_OFS, st(cc_pkg::attach_wait_sink, 2'b00), 32'h3F);
    wait_st(cc_pkg::attached_sink);
    repeat (4) @(posedge clk);
    #1 chk(32'(sink_current), 32'(adv));
    @(posedge clk);
    adv <= ~adv;
    repeat (5) @(posedge clk);
    #1 chk(32'(sink_current), 32'(adv));
    @(posedge clk);
    mode <= 2'h0;
    wait_st(cc_pkg::unattached_sink);
    // Direct attach on VBUS with no pull-up
    wr(cc_pkg::CTRL_OFS, 32'hC1);
    mode <= 2'h3;
    wait_st(cc_pkg::attached_sink);
    mode <= 2'h0;
    wait_st(cc_pkg::unattached_sink);
    // Dual role
    wr(cc_pkg::CTRL_OFS, 32'h82);
    wait_st(cc_pkg::unattached_source);
    wait_st(cc_pkg::unattached_sink);
    wait_st(cc_pkg::unattached_source);
    mode <= 2'h1;
    wait_st(cc_pkg::attached_source);
    mode <= 2'h0;
    wait_st(cc_pkg::unattached_sink);
    #1 chk(32'({vbus_en, vconn_en, rd_en}), 32'h1);
    @(posedge clk);
    mode <= 2'h2;
    wait_st(cc_pkg::attached_sink);
    mode <= 2'h0;
    wait_st(cc_pkg::unattached_sink);
    wait_st(cc_pkg::unattached_source);
    // Source preference
    wr(cc_pkg::CTRL_OFS, 32'h86);
    mode <= 2'h2;
    wait_st(cc_pkg::try_source);
    #1 chk(32'({rp_en, rd_en}), 32'h2);
    @(posedge clk);
    mode <= 2'h1;
    wait_st(cc_pkg::attached_source);
    mode <= 2'h0;
    wait_st(cc_pkg::unattached_sink);
    // Sink preference
    wr(cc_pkg::CTRL_OFS, 32'h8A);
    mode <= 2'h1;
    wait_st(cc_pkg::try_sink);
    #1 chk(32'({rp_en, rd_en}), 32'h1);
    @(posedge clk);
    mode <= 2'h2;
    wait_st(cc_pkg::attached_sink);
    mode <= 2'h0;
    wait_st(cc_pkg::unattached_sink);
    // Both preferences set: plain attach
    wr(cc_pkg::CTRL_OFS, 32'h8E);
    mode <= 2'h1;
    wait_st(cc_pkg::attached_source);
    results();
  end
endmodule
